// ===== hdl/drive_ctl_pkg.sv
// Package with constants, types and register map for the ramp select and start guard block
`default_nettype none
package drive_ctl_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Control: mode, guard enable, reset soft bit
   localparam logic [3:0] ADDR_ACC1   = 4'h1;  // First acceleration step
   localparam logic [3:0] ADDR_DEC1   = 4'h2;  // First deceleration step
   localparam logic [3:0] ADDR_ACC2   = 4'h3;  // Second acceleration step
   localparam logic [3:0] ADDR_DEC2   = 4'h4;  // Second deceleration step
   localparam logic [3:0] ADDR_TARGET = 4'h5;  // Target output frequency
   localparam logic [3:0] ADDR_FREQ   = 4'h6;  // Present output frequency (read only)
   localparam logic [3:0] ADDR_STATUS = 4'h7;  // State and error code (read only)
   localparam logic [3:0] ADDR_IRQ    = 4'h8;  // Sticky event bits, write one to clear
   localparam logic [3:0] ADDR_MASK   = 4'h9;  // Interrupt mask

   // Control register fields
   localparam int CTRL_METHOD_LSB = 0;      // Ramp switching method, two bits
   localparam int CTRL_GUARD_BIT  = 2;      // Start guard enable
   localparam int CTRL_KEY_RESET  = 3;      // Keypad stop/reset key, self clearing

   // Ramp switching method value that selects the input terminal
   localparam logic [1:0] METHOD_TERMINAL = 2'h0;

   // Input function codes, kept for software reference
   localparam logic [7:0] FUNC_RAMP_SELECT = 8'h09;
   localparam logic [7:0] FUNC_START_GUARD = 8'h13;

   // Error code reported in the start guard trip
   localparam logic [7:0] ERR_START_GUARD = 8'h0D;
   localparam logic [7:0] ERR_NONE        = 8'h00;

   // Reset pulse timing
   localparam int  CLK_HZ        = 25_000_000;
   localparam int  RESET_MIN_US  = 12_000;   // 12 ms least pulse
   localparam int  ALARM_CLR_US  = 30_000;   // 30 ms latest alarm clear
   localparam longint RESET_MIN_CYC = (longint'(RESET_MIN_US) * CLK_HZ + 999_999) / 1_000_000;

   // Interrupt event bit positions
   localparam int EV_TRIP  = 0;              // Entered start guard trip
   localparam int EV_CLEAR = 1;              // Trip cleared
   localparam int EV_SEL   = 2;              // Active ramp set changed
   localparam int EV_W     = 3;

   // Drive states, one-hot
   typedef enum logic [3:0] {
      ST_STOP = 4'h1,
      ST_RUN  = 4'h2,
      ST_TRIP = 4'h4,
      ST_COAST = 4'h8
   } drive_state_type;

   // Ramp step set handed to the ramp generator
   typedef struct packed {
      logic [15:0] acc;
      logic [15:0] dec;
   } ramp_set_type;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

endpackage : drive_ctl_pkg
`default_nettype wire

// ===== hdl/ramp_gen.sv
// Ramp generator: moves output frequency toward target at the given step rates
`timescale 1ns/10ps
`default_nettype none
module ramp_gen #(
   parameter int FW = 16                          // Frequency width
) (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       enable,   // Running; else decelerate to zero
   input  wire logic                       coast,    // Free run: output drops at once
   input  wire logic [FW-1:0]              target,
   input  wire drive_ctl_pkg::ramp_set_type rates,
   output logic      [FW-1:0]              freq
);
   import drive_ctl_pkg::*;

   logic [FW-1:0] goal;       // Where the ramp heads now
   logic [FW:0]   up_sum;     // Guarded sum against overflow

   assign goal   = enable ? target : '0;
   assign up_sum = {1'b0, freq} + {1'b0, rates.acc[FW-1:0]};

   // Only the step size depends on the rate set, so a set change keeps the
   // present frequency and alters slope from the next cycle on
   always_ff @(posedge clock) begin
      if (rst || coast) begin
         freq <= '0;
      end else if (freq < goal) begin
         freq <= (up_sum[FW-1:0] > goal || up_sum[FW]) ? goal : up_sum[FW-1:0];
      end else if (freq > goal) begin
         freq <= (freq - goal < rates.dec[FW-1:0]) ? goal : freq - rates.dec[FW-1:0];
      end
   end
endmodule : ramp_gen
`default_nettype wire

// ===== hdl/ramp_guard.sv
// Top: ramp set selection and unattended start guard for a motor drive
//
// What this block does
// - Select input high uses second ramp set
// - Select input low returns to first set
// - Set change applies at once mid-ramp
// - Select honoured only when method is 00
// - Second-set times are separate settings
// - Guard off: powerup run starts immediately
// - Guard on: powerup run trips, reports error
// - Run off or reset clears guard trip
// - After run-off clear, new run starts
// - Reset clear with run held resumes running
// - Guard still checked after undervoltage reset
// - Reset acts on release, held 12 ms
// - Alarm clears within 30 ms of reset
`timescale 1ns/10ps
`default_nettype none
module ramp_guard #(
   parameter int     FW            = 16,                         // Frequency width
   parameter longint RESET_MIN_CYCLES = drive_ctl_pkg::RESET_MIN_CYC  // Least reset pulse in clocks
) (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire logic                      second_ramp_select,  // Terminal, asynchronous
   input  wire logic                      run_cmd,             // Terminal, asynchronous
   input  wire logic                      reset_input,         // Terminal, asynchronous
   input  wire logic                      undervolt,           // Undervoltage trip, asynchronous
   input  wire drive_ctl_pkg::reg_req_type req,
   output logic      [31:0]               rdata,
   output logic      [FW-1:0]             out_freq,
   output logic                           running,
   output logic                           alarm,
   output logic      [7:0]                err_code,
   output logic                           irq
);
   import drive_ctl_pkg::*;

   localparam int RW = $clog2(RESET_MIN_CYCLES + 1);  // Pulse counter width

   // Synchronisers: first stage feeds only the second stage
   logic [3:0] meta_r;        // First stage
   logic [3:0] sync_r;        // Second stage
   logic sel_in, run_in, rsi_in, uv_in;
   assign sel_in = sync_r[0];
   assign run_in = sync_r[1];
   assign rsi_in = sync_r[2];
   assign uv_in  = sync_r[3];

   // Configuration registers
   logic [1:0]   method_r;     // Ramp switching method
   logic         guard_en_r;   // Start guard enable
   logic         key_reset_r;  // Keypad reset pulse, one cycle
   ramp_set_type set1_r;       // First ramp set
   ramp_set_type set2_r;       // Second ramp set, independent storage
   logic [FW-1:0] target_r;    // Target frequency
   logic [EV_W-1:0] ev_r;      // Sticky events
   logic [EV_W-1:0] mask_r;    // Event mask

   // Drive state
   drive_state_type state_r, state_nxt;
   logic         powerup_r;    // Set until first run decision after reset
   logic [RW-1:0] rs_cnt_r;    // Reset pulse width counter
   logic         rs_prev_r;    // Reset terminal last cycle
   logic         rs_ok;        // Valid reset pulse released
   logic         use_second;   // Second set active
   logic         use_second_r; // Last cycle's selection for event
   logic         trip_evt, clear_evt;
   ramp_set_type rates;
   logic [FW-1:0] freq_w;
   logic         rst_hold;     // Reset terminal held: motor output off

   // Two-flop synchroniser for all terminal inputs
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_r <= 4'h0;
         sync_r <= 4'h0;
      end else begin
         meta_r <= {undervolt, reset_input, run_cmd, second_ramp_select};
         sync_r <= meta_r;
      end
   end

   // Terminal select only counts under terminal method picks set
   assign use_second = (method_r == METHOD_TERMINAL) && sel_in;
   assign rates      = use_second ? set2_r : set1_r;   // Combinational: effect next cycle

   // Reset pulse qualifier: acts on release after a long enough high time
   always_ff @(posedge clock) begin
      if (rst) begin
         rs_cnt_r  <= '0;
         rs_prev_r <= 1'b0;
      end else begin
         rs_prev_r <= rsi_in;
         if (!rsi_in) begin
            rs_cnt_r <= '0;
         end else if (rs_cnt_r != RW'(RESET_MIN_CYCLES)) begin
            rs_cnt_r <= rs_cnt_r + 1'b1;
         end
      end
   end
   // Short pulses are ignored as glitches; a keypad press needs no width
   assign rs_ok    = (rs_prev_r && !rsi_in && rs_cnt_r == RW'(RESET_MIN_CYCLES)) || key_reset_r;
   assign rst_hold = rsi_in;

   // Next state of the drive
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STOP: begin
            // Powerup and post-undervoltage checks share the guard
            if (run_in && powerup_r && guard_en_r) begin
               state_nxt = ST_TRIP;
            end else if (run_in && !rst_hold) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (uv_in || rst_hold) begin
               state_nxt = ST_COAST;
            end else if (!run_in) begin
               state_nxt = ST_STOP;
            end
         end
         ST_TRIP: begin
            // Reset with run held resumes at once run off clears
            if (rs_ok && run_in) begin
               state_nxt = ST_RUN;
            end else if (rs_ok || !run_in) begin
               state_nxt = ST_STOP;
            end
         end
         ST_COAST: begin
            if (rs_ok) begin
               state_nxt = ST_STOP;
            end
         end
         default: begin
            state_nxt = ST_STOP;
         end
      endcase
   end

   // State register and powerup flag; undervoltage re-arms the guard check
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r   <= ST_STOP;
         powerup_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         if (uv_in) begin
            powerup_r <= 1'b1;
         end else if (state_r == ST_STOP && state_nxt == ST_STOP && !run_in) begin
            powerup_r <= 1'b0;                               // No run present: guard satisfied
         end else if (state_r == ST_TRIP) begin
            powerup_r <= 1'b0;
         end else if (state_nxt == ST_RUN) begin
            powerup_r <= 1'b0;
         end
      end
   end

   assign trip_evt  = (state_r != ST_TRIP) && (state_nxt == ST_TRIP);
   assign clear_evt = (state_r == ST_TRIP) && (state_nxt != ST_TRIP);

   // Ramp generator; coasting drops output at once
   ramp_gen #(
      .FW (FW)
   ) u_ramp (
      .clock  (clock),
      .rst    (rst),
      .enable (state_r == ST_RUN),
      .coast  (state_r == ST_COAST || state_r == ST_TRIP),
      .target (target_r),
      .rates  (rates),
      .freq   (freq_w)
   );

   // Registered outputs; alarm drops one cycle after the clearing event
   always_ff @(posedge clock) begin
      if (rst) begin
         out_freq <= '0;
         running  <= 1'b0;
         alarm    <= 1'b0;
         err_code <= ERR_NONE;
      end else begin
         out_freq <= freq_w;
         running  <= (state_nxt == ST_RUN);
         alarm    <= (state_nxt == ST_TRIP);
         err_code <= (state_nxt == ST_TRIP) ? ERR_START_GUARD : ERR_NONE;
      end
   end

   // Configuration writes; second set stored apart from the first
   always_ff @(posedge clock) begin
      if (rst) begin
         method_r    <= METHOD_TERMINAL;
         guard_en_r  <= 1'b0;
         key_reset_r <= 1'b0;
         set1_r      <= '0;
         set2_r      <= '0;
         target_r    <= '0;
         mask_r      <= '0;
      end else begin
         key_reset_r <= 1'b0;                                // Self clearing pulse
         if (req.wr) begin
            case (req.addr)
               ADDR_CTRL: begin
                  method_r    <= req.wdata[CTRL_METHOD_LSB +: 2];
                  guard_en_r  <= req.wdata[CTRL_GUARD_BIT];
                  key_reset_r <= req.wdata[CTRL_KEY_RESET];
               end
               ADDR_ACC1:   set1_r.acc <= req.wdata[15:0];
               ADDR_DEC1:   set1_r.dec <= req.wdata[15:0];
               ADDR_ACC2:   set2_r.acc <= req.wdata[15:0];
               ADDR_DEC2:   set2_r.dec <= req.wdata[15:0];
               ADDR_TARGET: target_r   <= req.wdata[FW-1:0];
               ADDR_MASK:   mask_r     <= req.wdata[EV_W-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // Sticky events: a set in the clearing cycle wins over the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         ev_r         <= '0;
         use_second_r <= 1'b0;
         irq          <= 1'b0;
      end else begin
         use_second_r <= use_second;
         ev_r <= (ev_r & ~((req.wr && req.addr == ADDR_IRQ) ? req.wdata[EV_W-1:0] : '0))
               | {use_second != use_second_r, clear_evt, trip_evt};
         irq  <= |(ev_r & mask_r);
      end
   end

   // Read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata <= 32'h0;
      end else begin
         rdata <= 32'h0;
         if (req.rd) begin
            case (req.addr)
               ADDR_CTRL:   rdata <= {28'h0, 1'b0, guard_en_r, method_r};
               ADDR_ACC1:   rdata <= {16'h0, set1_r.acc};
               ADDR_DEC1:   rdata <= {16'h0, set1_r.dec};
               ADDR_ACC2:   rdata <= {16'h0, set2_r.acc};
               ADDR_DEC2:   rdata <= {16'h0, set2_r.dec};
               ADDR_TARGET: rdata <= 32'(target_r);
               ADDR_FREQ:   rdata <= 32'(freq_w);
               ADDR_STATUS: rdata <= {16'h0, err_code, 3'h0, use_second, state_r};
               ADDR_IRQ:    rdata <= 32'(ev_r);
               ADDR_MASK:   rdata <= 32'(mask_r);
               default:     rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule : ramp_guard
`default_nettype wire

// ===== verif/ramp_guard_chk_sva.sv
// Checker of the ramp guard top's port behaviour
`timescale 1ns/10ps
`default_nettype none
module ramp_guard_chk
   import drive_ctl_pkg::*;
#(
   parameter int     FW               = 16,  // Frequency width
   parameter longint RESET_MIN_CYCLES = 8    // Least reset pulse in clocks
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       run_cmd,
   input wire logic       reset_input,
   input wire logic       running,
   input wire logic       alarm,
   input wire logic [7:0] err_code
);
   logic [31:0] hi_r;  // Clocks the reset terminal has stood high
   logic        long_r;  // Pulse long enough, with margin for the synchroniser
   // Measure the reset pulse so only full-width pulses are held to account
   always_ff @(posedge clock) begin
      if (rst || !reset_input) begin
         hi_r <= '0;
      end else if (hi_r != '1) begin
         hi_r <= hi_r + 32'h1;
      end
   end
   assign long_r = (hi_r >= RESET_MIN_CYCLES + 2);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_trip_code; alarm |-> err_code == ERR_START_GUARD; endproperty
   a_trip_code: assert property (p_trip_code) else $error("trip without its code");
   property p_no_code; !alarm |-> err_code == ERR_NONE; endproperty
   a_no_code: assert property (p_no_code) else $error("code outside trip");
   property p_trip_idle; alarm |-> !running; endproperty
   a_trip_idle: assert property (p_trip_idle) else $error("running in trip");
   property p_start_cause; $rose(running) |-> $past(run_cmd, 3); endproperty
   a_start_cause: assert property (p_start_cause) else $error("start without run");
   property p_run_off_clear; (!run_cmd) [*6] |-> !alarm; endproperty
   a_run_off_clear: assert property (p_run_off_clear) else $error("trip kept after run off");
   property p_run_off_stop; (!run_cmd) [*8] |-> !running; endproperty
   a_run_off_stop: assert property (p_run_off_stop) else $error("running without run");
   property p_pulse_clear; $fell(reset_input) && long_r |-> ##[1:6] !alarm; endproperty
   a_pulse_clear: assert property (p_pulse_clear) else $error("alarm kept after reset");
   property p_pulse_resume;
      $fell(reset_input) && long_r && alarm && run_cmd |-> ##[1:8] running;
   endproperty
   a_pulse_resume: assert property (p_pulse_resume) else $error("no resume after reset");
endmodule // ramp_guard_chk
bind ramp_guard ramp_guard_chk #(.FW(FW), .RESET_MIN_CYCLES(RESET_MIN_CYCLES)) ramp_guard_chk_i (
   .clock(clock), .rst(rst), .run_cmd(run_cmd), .reset_input(reset_input),
   .running(running), .alarm(alarm), .err_code(err_code));
`default_nettype wire

// ===== verif/term_model.sv
// Model of the control terminals and run command source
`timescale 1ns/10ps
`default_nettype none
module term_model (
   input  wire logic       clock,
   input  wire logic       run_req,    // Wanted run command level
   input  wire logic       sel_req,    // Wanted ramp set level
   input  wire logic       uv_req,     // Wanted undervoltage level
   input  wire logic [7:0] pulse_len,  // Reset pulse width, one clock wide request
   output logic            run_cmd,
   output logic            second_ramp_select,
   output logic            undervolt,
   output logic            reset_input
);
   logic [7:0] left_r = 8'h0;  // Clocks of reset pulse still to run
   // Contacts follow the wanted levels a clock later
   always_ff @(posedge clock) begin
      run_cmd            <= run_req;
      second_ramp_select <= sel_req;
      undervolt          <= uv_req;
   end
   // Whole pulse width is held before release; short widths only when asked
   always_ff @(posedge clock) begin
      if (left_r != 8'h0) begin
         left_r <= left_r - 8'h1;
      end else begin
         left_r <= pulse_len;
      end
   end
   assign reset_input = (left_r != 8'h0);
endmodule // term_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the ramp guard top
`timescale 1ns/10ps
`default_nettype none
module tb;
   import drive_ctl_pkg::*;
   localparam longint RMIN = 8;  // Short reset width keeps the run brief
   logic        clock, rst, run_req, sel_req, uv_req;
   logic [7:0]  pulse_len, err_code;
   wire         run_cmd, second_ramp_select, undervolt, reset_input;
   reg_req_type req;
   logic [31:0] rdata;
   logic [15:0] out_freq, a1, a2, d1, d2, dl;
   logic        running, alarm, irq, rd_d;
   logic [31:0] exp_q[$];  // Expected read data, oldest first
   int          mismatches, n_tests;
   ramp_guard #(.RESET_MIN_CYCLES(RMIN)) ramp_guard_i (.clock(clock), .rst(rst),
      .second_ramp_select(second_ramp_select), .run_cmd(run_cmd), .reset_input(reset_input),
      .undervolt(undervolt), .req(req), .rdata(rdata), .out_freq(out_freq), .running(running),
      .alarm(alarm), .err_code(err_code), .irq(irq));
   term_model term_model_i (.clock(clock), .run_req(run_req), .sel_req(sel_req), .uv_req(uv_req),
      .pulse_len(pulse_len), .run_cmd(run_cmd), .second_ramp_select(second_ramp_select),
      .undervolt(undervolt), .reset_input(reset_input));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data stands one cycle after the strobe; compare it with the oldest note
   always @(posedge clock) begin
      if (rd_d) check(rdata, exp_q.pop_front());
      rd_d <= req.rd;
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      req.addr <= a;
      req.rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      req.rd <= 1'b0;
   endtask
   // Bounded wait on running (k 0) or alarm (k 1)
   task automatic wait_for(input int k, input logic v);
      for (int j = 0; j < 60; j++) begin
         @(posedge clock);
         if ((k == 0 ? running : alarm) === v) return;
      end
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic pulse(input logic [7:0] n);
      @(posedge clock);
      pulse_len <= n;
      @(posedge clock);
      pulse_len <= 8'h0;
      repeat (n + 4) @(posedge clock);
   endtask
   // Powerup with undervoltage standing, so the guard is armed whatever the order
   task automatic power_up(input logic run, input logic [31:0] ctrl);
      rst <= 1'b1;
      run_req <= run;
      uv_req <= 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      wr(ADDR_CTRL, ctrl);
      uv_req <= 1'b0;
      pulse(8'd12);
   endtask
   // Frequency change over one clock, after the terminals settle
   task automatic step_is(input logic [15:0] e);
      logic [15:0] f;
      repeat (6) @(posedge clock);
      f = out_freq;
      @(posedge clock);
      dl = out_freq - f;
      check(dl, e);
   endtask
   initial begin
      rst = 1'b1;
      req = '0;
      {run_req, sel_req, uv_req} = 3'h0;
      pulse_len = 8'h0;
      void'($urandom(87310));
      a1 = 16'($urandom_range(1, 15));
      a2 = 16'($urandom_range(16, 31));
      d1 = 16'($urandom_range(1, 7));
      d2 = 16'($urandom_range(8, 15));
      power_up(1'b0, 32'h0);
      rd(ADDR_STATUS, 32'h1);
      rd(ADDR_MASK, 32'h0);
      rd(4'hF, 32'h0);
      wr(ADDR_FREQ, 32'hFFFF);
      rd(ADDR_FREQ, 32'h0);
      wr(ADDR_ACC2, {16'h0, a2});
      rd(ADDR_ACC2, {16'h0, a2});
      $display("test registers done");
      power_up(1'b1, 32'h4);
      wait_for(1, 1'b1);
      check(running, 1'b0);
      rd(ADDR_STATUS, {16'h0, ERR_START_GUARD, 8'h04});
      check(irq, 1'b0);
      wr(ADDR_MASK, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 1'b1);
      wr(ADDR_IRQ, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      run_req <= 1'b0;
      wait_for(1, 1'b0);
      check(err_code, ERR_NONE);
      rd(ADDR_IRQ, 32'h2);
      run_req <= 1'b1;
      wait_for(0, 1'b1);
      $display("test guard run off done");
      power_up(1'b1, 32'h4);
      wait_for(1, 1'b1);
      pulse(8'd3);
      check(alarm, 1'b1);
      pulse(8'd12);
      check(alarm, 1'b0);
      wait_for(0, 1'b1);
      $display("test reset terminal done");
      power_up(1'b1, 32'h4);
      wait_for(1, 1'b1);
      wr(ADDR_CTRL, 32'hC);
      wait_for(1, 1'b0);
      wait_for(0, 1'b1);
      $display("test keypad reset done");
      power_up(1'b1, 32'h0);
      wait_for(0, 1'b1);
      check(alarm, 1'b0);
      wr(ADDR_ACC1, {16'h0, a1});
      wr(ADDR_ACC2, {16'h0, a2});
      wr(ADDR_DEC1, {16'h0, d1});
      wr(ADDR_DEC2, {16'h0, d2});
      wr(ADDR_TARGET, 32'hF000);
      step_is(a1);
      sel_req <= 1'b1;
      step_is(a2);
      step_is(a2);
      rd(ADDR_STATUS, 32'h12);
      rd(ADDR_IRQ, 32'h4);
      wr(ADDR_CTRL, 32'h1);
      step_is(a1);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_TARGET, 32'h0);
      step_is(16'h0 - d2);
      sel_req <= 1'b0;
      step_is(16'h0 - d1);
      $display("test ramp sets done");
      close_out();
   end
endmodule // tb
`default_nettype wire
